/* File: verilog/kwd_watchdog.sv */
/*
 * Keyed watchdog timer with Wishbone register access.
 * Assumes the core pulses clear_watchdog_instr_i and halt_instr_i for one clock, holds sleep_i while in a
 * sleep or idle mode, and routes chip_rst_o and pc_sp_rst_o into its reset network.
 */
// The placing of the registers and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

`include "kwd_defines.svh"

module kwd_watchdog
    import kwd_pkg::*;
#(
    parameter int KEY_DELAY_CYC = `KWD_KEY_DELAY
) (
    // Clock, reset, enable
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Oscillators and configuration option
    input  wire logic        low_speed_crystal_i,
    input  wire logic        low_speed_rc_osc_i,
    input  wire logic        sub_src_crystal_i,
    // Core and pins
    input  wire logic        external_reset_pin_n_i,
    input  wire logic        clear_watchdog_instr_i,
    input  wire logic        halt_instr_i,
    input  wire logic        sleep_i,
    // Reset and status outputs
    output logic             chip_rst_o,
    output logic             pc_sp_rst_o,
    output logic             pc_clear_o,
    output logic             timeout_status_flag_o,
    output logic             power_down_flag_o,
    output logic             idle_sysclk_keep_o
);
    if (KEY_DELAY_CYC < 2 || KEY_DELAY_CYC > 3) begin : g_bad_delay
        $error("KEY_DELAY_CYC must be 2 or 3");
    end

    localparam logic [1:0] KEY_LAST = 2'(KEY_DELAY_CYC - 1);

    kwd_state_t s;
    kwd_state_t next_s;

    kwd_sync_if #(.W(3)) pins ();

    assign pins.raw = {external_reset_pin_n_i, low_speed_rc_osc_i, low_speed_crystal_i};

    kwd_sync #(
        .W       (3),
        .RST_VAL (`KWD_SYNC_POR)
    ) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ce_i  (ce_i),
        .sif   (pins.dst)
    );

    function automatic logic [17:0] period_mask(input logic [2:0] sel);
        logic [4:0] sh;
        unique case (sel)
            3'h0: sh = `KWD_SHIFT_0;
            3'h1: sh = `KWD_SHIFT_1;
            3'h2: sh = `KWD_SHIFT_2;
            3'h3: sh = `KWD_SHIFT_3;
            3'h4: sh = `KWD_SHIFT_4;
            3'h5: sh = `KWD_SHIFT_5;
            3'h6: sh = `KWD_SHIFT_6;
            3'h7: sh = `KWD_SHIFT_7;
        endcase
        return 18'((19'h00001 << sh) - 19'h00001);
    endfunction

    logic [4:0]  key;
    logic        key_en;
    logic        key_dis;
    logic        key_bad;
    logic        sub_lvl;
    logic        sub_tick;
    logic        rc_tick;
    logic        pin_rst;
    logic        cnt_clr;
    logic [17:0] mask;
    logic        wd_ovf;
    logic        key_fire;
    logic        bus_req;
    logic        bus_wr;

    assign key     = s.wdc[`KWD_KEY_MSB:`KWD_KEY_LSB];
    assign key_en  = (key == `KWD_KEY_ENABLE);
    assign key_dis = (key == `KWD_KEY_DISABLE);
    assign key_bad = !key_en && !key_dis;
    assign sub_lvl   = sub_src_crystal_i ? pins.sync[0] : pins.sync[1];
    assign sub_tick  = sub_lvl && !s.sub_prev;
    assign rc_tick   = pins.sync[1] && !s.rc_prev;
    assign pin_rst   = !pins.sync[2];
    assign key_fire  = key_bad && rc_tick && (s.key_wait == KEY_LAST);
    assign cnt_clr   = pin_rst || clear_watchdog_instr_i || halt_instr_i || key_fire;
    assign mask      = period_mask(s.wdc[`KWD_SEL_MSB:0]);
    assign wd_ovf    = key_en && sub_tick && !cnt_clr && ((s.cnt & mask) == mask);
    assign bus_req   = wb_cyc_i && wb_stb_i && !s.ack;
    assign bus_wr    = bus_req && wb_we_i && wb_sel_i[0];

    always_comb begin
        next_s           = s;
        next_s.ack       = 1'b0;
        next_s.chip_rst  = 1'b0;
        next_s.pcsp_rst  = 1'b0;
        next_s.pc_clear  = 1'b0;
        next_s.sub_prev  = sub_lvl;
        next_s.rc_prev   = pins.sync[1];

        // Writes land in the same edge that raises ack.
        if (bus_req) begin
            next_s.ack = 1'b1;
            unique case (wb_adr_i[3:2])
                `KWD_ADR_WDC: next_s.rdata = {24'h000000, s.wdc};
                `KWD_ADR_SYS: next_s.rdata = {24'h000000, s.idle_keep, 4'h0, s.lowv,
                                              s.lvkrf, s.keyrf};
                `KWD_ADR_STAT: next_s.rdata = {6'h00, s.cnt, 5'h00, key_en,
                                               s.pwrdn_flag, s.to_flag};
                default: next_s.rdata = 32'h00000000;
            endcase
        end
        if (bus_wr) begin
            if (wb_adr_i[3:2] == `KWD_ADR_WDC) begin
                next_s.wdc = wb_dat_i[7:0];
            end
            if (wb_adr_i[3:2] == `KWD_ADR_SYS) begin
                next_s.idle_keep = wb_dat_i[`KWD_SYS_IDLE];
                next_s.lowv      = wb_dat_i[`KWD_SYS_LOWV];
                next_s.lvkrf     = wb_dat_i[`KWD_SYS_LVKRF];
                if (!wb_dat_i[`KWD_SYS_KEYRF]) begin
                    next_s.keyrf = 1'b0;
                end
            end
        end

        if (!key_bad) begin
            next_s.key_wait = 2'h0;
        end else if (key_fire) begin
            next_s.key_wait = 2'h0;
            next_s.wdc      = `KWD_WDC_POR;
            // mark the key source, set beats clear
            next_s.keyrf    = 1'b1;
            next_s.chip_rst = 1'b1;
            next_s.pc_clear = 1'b1;
        end else if (rc_tick) begin
            next_s.key_wait = 2'(s.key_wait + 2'h1);
        end

        if (halt_instr_i) begin
            next_s.pwrdn_flag = 1'b1;
            next_s.to_flag    = 1'b0;
        end else if (clear_watchdog_instr_i) begin
            next_s.pwrdn_flag = 1'b0;
        end

        // halt only clears, the counter keeps running on sub ticks
        if (cnt_clr) begin
            next_s.cnt = 18'h00000;
        end else if (wd_ovf) begin
            next_s.cnt      = 18'h00000;
            next_s.to_flag  = 1'b1;
            next_s.pc_clear = 1'b1;
            if (sleep_i) begin
                next_s.pcsp_rst = 1'b1;
            end else begin
                next_s.chip_rst = 1'b1;
            end
        end else if (key_en && sub_tick) begin
            next_s.cnt = 18'(s.cnt + 18'h00001);
        end

        // The pin reset is held for as long as the pin stays low.
        if (pin_rst) begin
            next_s.chip_rst = 1'b1;
            next_s.pc_clear = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s       <= '0;
            s.wdc   <= `KWD_WDC_POR;
            s.lowv  <= 1'b0;
        end else if (ce_i) begin
            s <= next_s;
        end
    end

    assign wb_dat_o              = s.rdata;
    assign wb_ack_o              = s.ack;
    assign chip_rst_o            = s.chip_rst;
    assign pc_sp_rst_o           = s.pcsp_rst;
    assign pc_clear_o            = s.pc_clear;
    assign timeout_status_flag_o = s.to_flag;
    assign power_down_flag_o     = s.pwrdn_flag;
    assign idle_sysclk_keep_o    = s.idle_keep;

    chk_key_default: assert property (
        @(posedge clk_i) $fell(rst_i) |-> (s.wdc == `KWD_WDC_POR))
        else $error("watchdog control not at power-on value");

    chk_disabled_hold: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && key_dis && !cnt_clr && !pin_rst)
        |=> (s.cnt == $past(s.cnt)) && !s.chip_rst && !s.pcsp_rst)
        else $error("disabled watchdog counted or reset");

    chk_enable_count: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && key_en && sub_tick && !cnt_clr && !wd_ovf)
        |=> (s.cnt == 18'($past(s.cnt) + 18'h00001)))
        else $error("enabled watchdog did not count");

    chk_bad_key_reset: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && key_bad && rc_tick && s.key_wait == KEY_LAST)
        |=> s.chip_rst && s.keyrf && (s.wdc == `KWD_WDC_POR) ##1 !s.chip_rst || pin_rst)
        else $error("invalid key did not reset");

    chk_key_sticky: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (s.keyrf && !(bus_wr && wb_adr_i[3:2] == `KWD_ADR_SYS && !wb_dat_i[0]))
        |=> s.keyrf)
        else $error("key reset flag lost without software clear");

    chk_timeout_full: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && wd_ovf && !sleep_i) |=> s.chip_rst && s.to_flag && s.pc_clear)
        else $error("overflow in run mode without full reset");

    chk_timeout_sleep: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && wd_ovf && sleep_i && !pin_rst)
        |=> s.pcsp_rst && !s.chip_rst && s.to_flag ##1 !s.pcsp_rst)
        else $error("overflow asleep did not give partial reset");

    chk_clear_sources: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && cnt_clr) |=> (s.cnt == 18'h00000))
        else $error("clear source left counter nonzero");

    chk_unused_zero: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && bus_req && !wb_we_i && wb_adr_i[3:2] == `KWD_ADR_SYS)
        |=> wb_ack_o && (wb_dat_o[6:3] == 4'h0))
        else $error("unused system control bits read nonzero");

    chk_halt_flags: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && halt_instr_i) |=> s.pwrdn_flag && !s.to_flag)
        else $error("halt did not set power-down and clear time-out");

    chk_reset_pc: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (s.chip_rst || s.pcsp_rst) |-> s.pc_clear)
        else $error("device reset without program counter clear");

    chk_key_wait_clear: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && !key_bad) |=> (s.key_wait == 2'h0))
        else $error("valid key left the wait count running");

    chk_key_set_only: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && !s.keyrf && !key_fire) |=> !s.keyrf)
        else $error("key reset flag set without an invalid key");

    chk_pin_reset: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && pin_rst) |=> s.chip_rst && s.pc_clear && (s.cnt == 18'h00000))
        else $error("low reset pin did not reset and clear");

    chk_tick_only: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && !sub_tick && !cnt_clr) |=> (s.cnt == $past(s.cnt)))
        else $error("counter moved without a sub clock tick");

    chk_ratio_min: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && wd_ovf) |-> (s.cnt[7:0] == 8'hff))
        else $error("overflow before the shortest period");

    chk_ratio_max: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && wd_ovf && s.wdc[2:0] == 3'h7) |-> (s.cnt == 18'h3ffff))
        else $error("longest period overflowed early");

    chk_halt_resume: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && halt_instr_i) |=> (s.cnt == 18'h00000) && s.pwrdn_flag)
        else $error("halt did not clear the counter");
endmodule // kwd_watchdog

`default_nettype wire

/* File: verilog/kwd_defines.svh */
/*
 * Offsets, field positions, reset values and timing counts of the keyed watchdog.
 * Assumes a 32-bit classic Wishbone slave with byte addresses on a 4-bit address.
 */
`ifndef KWD_DEFINES_SVH
`define KWD_DEFINES_SVH

`define KWD_ADR_WDC      2'h0
`define KWD_ADR_SYS      2'h1
`define KWD_ADR_STAT     2'h2

`define KWD_KEY_ENABLE   5'h0a
`define KWD_KEY_DISABLE  5'h15
`define KWD_WDC_POR      8'h53
`define KWD_KEY_MSB      7
`define KWD_KEY_LSB      3
`define KWD_SEL_MSB      2

`define KWD_SYS_IDLE     7
`define KWD_SYS_LOWV     2
`define KWD_SYS_LVKRF    1
`define KWD_SYS_KEYRF    0

`define KWD_SHIFT_0      5'd8
`define KWD_SHIFT_1      5'd10
`define KWD_SHIFT_2      5'd12
`define KWD_SHIFT_3      5'd14
`define KWD_SHIFT_4      5'd15
`define KWD_SHIFT_5      5'd16
`define KWD_SHIFT_6      5'd17
`define KWD_SHIFT_7      5'd18

`define KWD_KEY_DELAY    2
`define KWD_SYNC_POR     3'h4

`endif

/* File: verilog/kwd_pkg.sv */
/*
 * Types of the keyed watchdog.
 * Field widths are written out as literals; the types take nothing from kwd_defines.svh.
 */
`default_nettype none

package kwd_pkg;

    typedef struct packed {
        logic [7:0]  wdc;
        logic        idle_keep;
        logic        lowv;
        logic        lvkrf;
        logic        keyrf;
        logic        to_flag;
        logic        pwrdn_flag;
        logic [17:0] cnt;
        logic [1:0]  key_wait;
        logic        sub_prev;
        logic        rc_prev;
        logic        ack;
        logic [31:0] rdata;
        logic        chip_rst;
        logic        pcsp_rst;
        logic        pc_clear;
    } kwd_state_t;

endpackage : kwd_pkg

`default_nettype wire

/* File: verilog/kwd_sync_if.sv */
/*
 * Carrier between the watchdog core and its pin synchroniser.
 * Assumes both ends run on the system clock.
 */
`timescale 1ns/1ns
`default_nettype none

interface kwd_sync_if #(
    parameter int W = 3
);
    logic [W-1:0] raw;
    logic [W-1:0] sync;

    modport src (output raw, input sync);
    modport dst (input raw, output sync);
endinterface : kwd_sync_if

`default_nettype wire

/* File: verilog/kwd_sync.sv */
/*
 * Three-stage pin synchroniser with agreement filter.
 * Assumes raw inputs are asynchronous to clk_i; the output moves only when stages two
 * and three agree.
 */
`timescale 1ns/1ns
`default_nettype none

module kwd_sync #(
    parameter int         W       = 3,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and control
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    // Pins in, filtered levels out
    kwd_sync_if.dst   sif
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] out;
    } kwd_sync_st_t;

    kwd_sync_st_t s;
    kwd_sync_st_t next_s;

    always_comb begin
        next_s    = s;
        next_s.s1 = sif.raw;
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
        for (int i = 0; i < W; i++) begin
            if (s.s2[i] == s.s3[i]) begin
                next_s.out[i] = s.s3[i];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, out: RST_VAL};
        end else if (ce_i) begin
            s <= next_s;
        end
    end

    assign sif.sync = s.out;
endmodule // kwd_sync

`default_nettype wire

/* File: sim/kwd_core_model.sv */
/*
 * Core model that issues clear and halt pulses and holds the sleep level.
 * Assumes the watchdog samples these on the rising edge of clk_i.
 */
`timescale 1ns/1ns
`default_nettype none

module kwd_core_model (
    // Clock
    input  wire logic clk_i,
    // Core requests
    output logic      clr_o,
    output logic      halt_o,
    output logic      sleep_o
);
    initial begin
        clr_o = 1'b0;
        halt_o = 1'b0;
        sleep_o = 1'b0;
    end

    task automatic kick();
        @(posedge clk_i);
        clr_o <= 1'b1;
        @(posedge clk_i);
        clr_o <= 1'b0;
    endtask

    // clears spaced by gap cycles, slow or prompt as asked.
    task automatic keep(input int n, input int gap);
        repeat (n) begin
            repeat (gap) @(posedge clk_i);
            kick();
        end
    endtask

    // A halt enters sleep when s is set.
    task automatic halt(input logic s);
        @(posedge clk_i);
        halt_o <= 1'b1;
        sleep_o <= s;
        @(posedge clk_i);
        halt_o <= 1'b0;
    endtask

    task automatic wake();
        @(posedge clk_i);
        sleep_o <= 1'b0;
    endtask
endmodule // kwd_core_model

`default_nettype wire

/* File: sim/tb_kwd_watchdog.sv */
/*
 * Self-checking bench of the keyed watchdog, driven over Wishbone.
 * Assumes the core model beside it and oscillators made from the system clock.
 */
`timescale 1ns/1ns
`default_nettype none

module tb_kwd_watchdog;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        req = 1'b0;
    logic        we = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic [3:0]  sel = 4'hf;
    logic [31:0] dat = 32'h0;
    logic [31:0] rdat;
    logic        ack;
    logic        xtal = 1'b0;
    logic        rc_osc = 1'b0;
    logic        ce = 1'b1;
    logic        xsel = 1'b0;
    logic        run_x = 1'b0;
    logic        pin_n = 1'b1;
    logic        clr, halt, sleep;
    logic        chip_rst, pcsp, pcclr, to_f, pd_f, idle_k;
    logic [2:0]  div = 3'h0;
    logic [31:0] q;
    int          n_mismatch = 0;
    int          checked = 0;
    int          n_rst = 0;
    int          cyc_n = 0;
    int          n, t, base;

    always #5 clk_i = ~clk_i;

    // Sub clocks toggle every four cycles so the pin filter passes them.
    always @(posedge clk_i) begin
        div <= div + 3'h1;
        rc_osc <= div[2];
        xtal <= div[2] & run_x;
        if (chip_rst === 1'b1 || pcsp === 1'b1) n_rst <= n_rst + 1;
        cyc_n <= cyc_n + 1;
        if (cyc_n == 60000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    kwd_core_model kwd_core_model_i (.clk_i(clk_i), .clr_o(clr), .halt_o(halt),
        .sleep_o(sleep));

    kwd_watchdog kwd_watchdog_i (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
        .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .low_speed_crystal_i(xtal), .low_speed_rc_osc_i(rc_osc),
        .sub_src_crystal_i(xsel), .external_reset_pin_n_i(pin_n),
        .clear_watchdog_instr_i(clr), .halt_instr_i(halt), .sleep_i(sleep),
        .chip_rst_o(chip_rst), .pc_sp_rst_o(pcsp), .pc_clear_o(pcclr),
        .timeout_status_flag_o(to_f), .power_down_flag_o(pd_f),
        .idle_sysclk_keep_o(idle_k));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Request stands until ack is sampled high or 64 cycles pass; then it is released.
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        req <= 1'b1;
        we <= w;
        adr <= a;
        dat <= {24'h0, d};
        do begin
            @(posedge clk_i);
            k++;
        end while (ack !== 1'b1 && k < 64);
        q = rdat;
        req <= 1'b0;
        if (k >= 64) begin
            n_mismatch++;
            give_verdict();
        end
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        wb(1'b0, a, 8'h0);
        check(q, e);
    endtask

    task automatic wait_rst(input int lim, output int k);
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (chip_rst !== 1'b1 && pcsp !== 1'b1 && k < lim);
        if (k < lim) check(pcclr, 1'b1);
    endtask

    task automatic give_verdict();
        if (n_mismatch == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(4'h0, 32'h53);
        // A write with the low byte lane off must leave the key alone.
        sel <= 4'he;
        wb(1'b1, 4'h0, 8'h00);
        sel <= 4'hf;
        rd(4'h0, 32'h53);
        wb(1'b1, 4'h4, 8'hff);
        rd(4'h4, 32'h86);
        check(idle_k, 1'b1);
        wb(1'b1, 4'h4, 8'h00);
        rd(4'hc, 32'h0);
        // Crystal as sub clock, periods of 2^8 and 2^10 ticks of 8 cycles.
        xsel <= 1'b1;
        run_x <= 1'b1;
        for (int s = 0; s < 2; s++) begin
            wb(1'b1, 4'h0, {5'h0a, 3'(s)});
            kwd_core_model_i.kick();
            wait_rst(12000, n);
            t = (s == 0) ? 2048 : 8192;
            check(32'(n > t - 24 && n < t + 24), 32'h1);
            check({pcsp, chip_rst, to_f}, 3'b011);
        end
        // A stopped crystal must stop the count.
        run_x <= 1'b0;
        kwd_core_model_i.kick();
        wait_rst(3000, n);
        check(n, 3000);
        xsel <= 1'b0;
        wb(1'b1, 4'h0, {5'h0a, 3'h0});
        kwd_core_model_i.halt(1'b1);
        @(posedge clk_i);
        check({pd_f, to_f}, 2'b10);
        wait_rst(3000, n);
        check(32'(n > 2024 && n < 2072), 32'h1);
        check({pcsp, chip_rst, to_f}, 3'b101);
        kwd_core_model_i.wake();
        base = n_rst;
        kwd_core_model_i.keep(4, 1500);
        check(n_rst, base);
        check(pd_f, 1'b0);
        wb(1'b1, 4'h0, {5'h15, 3'h0});
        repeat (3000) @(posedge clk_i);
        check(n_rst, base);
        for (int i = 0; i < 2; i++) begin
            wb(1'b1, 4'h0, {(i == 0) ? 5'h00 : 5'h1f, 3'h0});
            wait_rst(64, n);
            check(32'(n >= 8 && n <= 32), 32'h1);
            rd(4'h4, 32'h01);
            rd(4'h0, 32'h53);
            wb(1'b1, 4'h4, 8'h01);
            rd(4'h4, 32'h01);
            wb(1'b1, 4'h4, 8'h00);
            rd(4'h4, 32'h00);
        end
        wb(1'b1, 4'h0, 8'h50);
        repeat (1000) @(posedge clk_i);
        pin_n <= 1'b0;
        wait_rst(16, n);
        check(32'(n <= 8), 32'h1);
        wb(1'b0, 4'h8, 8'h0);
        check(q[25:8], 18'h0);
        check(q[2:0], 3'b101);
        pin_n <= 1'b1;
        repeat (10) @(posedge clk_i);
        // A pin pulse while the clock enable is low must not reach the core.
        base = n_rst;
        ce <= 1'b0;
        pin_n <= 1'b0;
        repeat (20) @(posedge clk_i);
        pin_n <= 1'b1;
        repeat (4) @(posedge clk_i);
        ce <= 1'b1;
        repeat (20) @(posedge clk_i);
        check(n_rst, base);
        give_verdict();
    end
endmodule // tb_kwd_watchdog

`default_nettype wire
